// *** irc_pkg.sv ***
// constants for the storage-redirection configuration header block
package irc_pkg;
    // ------------------------------------------------------------
    // register offsets (dword index = byte offset >> 2)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD_STAT  = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h06;
    localparam logic [7:0] OFS_REV_CLASS = 8'h08;
    localparam logic [7:0] OFS_CLASS     = 8'h09;
    localparam logic [7:0] OFS_LINE_TMR  = 8'h0c;
    localparam logic [7:0] OFS_LINE_SIZE = 8'h0c;
    localparam logic [7:0] OFS_HOLD_TMR  = 8'h0d;
    localparam logic [7:0] OFS_CMD_BASE  = 8'h10;
    localparam logic [7:0] OFS_CTL_BASE  = 8'h14;

    // ------------------------------------------------------------
    // fields and fixed values
    // ------------------------------------------------------------
    localparam int          POS_INT_DISABLE  = 10;
    localparam int          POS_INT_PENDING  = 3;
    localparam logic [15:0] STS_FIXED        = 16'h00b0;
    localparam logic [23:0] CLASS_TRIPLET    = 24'h010185;
    localparam logic [7:0]  LINE_SIZE_VAL    = 8'h00;
    localparam logic [7:0]  HOLD_TMR_VAL     = 8'h00;
    localparam logic [31:0] IO_BASE_RESET    = 32'h00000001;
    localparam logic [31:0] CMD_BASE_WMASK   = 32'h0000fff8;
    localparam logic [31:0] CTL_BASE_WMASK   = 32'h0000fffc;
    localparam logic [15:0] CMD_WORD_WMASK   = 16'h0405;
    localparam logic [15:0] CMD_WORD_RESET   = 16'h0000;
    localparam logic [7:0]  REVISION_DEFAULT = 8'h00; // arbitrary value

    // power states of the function
    typedef enum logic [1:0] {PWR_D0, PWR_D1, PWR_D2, PWR_D3} irc_pwr_t;
endpackage : irc_pkg

// *** irc_base_reg.sv ***
// one io base register with write mask and d3 to d0 default reload
`timescale 1ns/10ps
module irc_base_reg
    import irc_pkg::*;
#(
    parameter logic [31:0] WMASK = CMD_BASE_WMASK
)(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        reload,
    input  wire logic        wr,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata,
    output logic [31:0]      q
);
    logic [31:0] q_nxt;
    logic [31:0] lane_m;

    // ------------------------------------------------------------
    // next value: masked byte-lane merge
    // ------------------------------------------------------------
    always_comb
    begin
        lane_m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WMASK;
        q_nxt  = q;
        if (reload)
        begin
            q_nxt = IO_BASE_RESET;
        end
        else if (wr)
        begin
            q_nxt = (q & ~lane_m) | (wdata & lane_m);
        end
        q_nxt = (q_nxt & WMASK) | IO_BASE_RESET;
    end

    // register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= IO_BASE_RESET;
        else if (ce)
            q <= q_nxt;
    end

    a_base_bit0: assert property (@(posedge clk) disable iff (!rstn)
        ##1 (q[0] == 1'b1 && q[31:16] == 16'h0000))
        else $error("io base fixed bits wrong");
endmodule : irc_base_reg

// *** irc_intx.sv ***
// legacy interrupt gating from pending state and disable bit
`timescale 1ns/10ps
module irc_intx
    import irc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic int_state,
    input  wire logic interrupt_disable,
    output logic      interrupt_pending,
    output logic      legacy_interrupt_line_c
);
    logic pend_nxt;
    logic line_nxt;

    // ------------------------------------------------------------
    // pending tracks state; line is masked copy
    // ------------------------------------------------------------
    always_comb
    begin
        pend_nxt = int_state;
        line_nxt = int_state & ~interrupt_disable;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            interrupt_pending       <= 1'b0;
            legacy_interrupt_line_c <= 1'b0;
        end
        else if (ce)
        begin
            interrupt_pending       <= pend_nxt;
            legacy_interrupt_line_c <= line_nxt;
        end
    end

    a_line_mask: assert property (@(posedge clk) disable iff (!rstn)
        ce && interrupt_disable |=> !legacy_interrupt_line_c)
        else $error("interrupt line raised while disabled");
    a_pend_free: assert property (@(posedge clk) disable iff (!rstn)
        ce |=> interrupt_pending == $past(int_state))
        else $error("pending does not follow state");
endmodule : irc_intx

// *** irc_cfg_header.sv ***
// configuration header registers of the redirected storage function
`timescale 1ns/10ps
module irc_cfg_header
    import irc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [1:0]  pwr_state,
    input  wire logic        int_state,
    input  wire logic [7:0]  silicon_revision,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_ack,
    output logic             legacy_interrupt_line_c,
    output logic [31:0]      cmd_base,
    output logic [31:0]      ctl_base
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] cmd_word_r;
    logic [15:0] cmd_word_nxt;
    irc_pwr_t    pwr_s1_r;
    irc_pwr_t    pwr_s2_r;
    irc_pwr_t    pwr_prev_r;
    logic        reload;
    logic        interrupt_pending;
    logic        interrupt_disable;
    logic        wr_cmd;
    logic        wr_cmdb;
    logic        wr_ctlb;
    logic [15:0] device_status_word;
    logic [31:0] rdata_nxt;
    logic        int_line;

    // decode helper: dword index match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    // ------------------------------------------------------------
    // power state sync and d3 to d0 detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr_s1_r   <= PWR_D0;
            pwr_s2_r   <= PWR_D0;
            pwr_prev_r <= PWR_D0;
        end
        else if (ce)
        begin
            pwr_s1_r   <= irc_pwr_t'(pwr_state);
            pwr_s2_r   <= pwr_s1_r;
            pwr_prev_r <= pwr_s2_r;
        end
    end
    assign reload = (pwr_prev_r == PWR_D3) && (pwr_s2_r == PWR_D0);

    // ------------------------------------------------------------
    // command word (only disable and enables kept)
    // ------------------------------------------------------------
    assign wr_cmd  = cfg_wr && hit(cfg_addr, OFS_CMD_STAT);
    assign wr_cmdb = cfg_wr && hit(cfg_addr, OFS_CMD_BASE);
    assign wr_ctlb = cfg_wr && hit(cfg_addr, OFS_CTL_BASE);

    always_comb
    begin
        cmd_word_nxt = cmd_word_r;
        if (reload)
            cmd_word_nxt = CMD_WORD_RESET;
        else if (wr_cmd)
        begin
            if (cfg_be[0])
                cmd_word_nxt[7:0] = cfg_wdata[7:0] & CMD_WORD_WMASK[7:0];
            if (cfg_be[1])
                cmd_word_nxt[15:8] = cfg_wdata[15:8] & CMD_WORD_WMASK[15:8];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cmd_word_r <= CMD_WORD_RESET;
        else if (ce)
            cmd_word_r <= cmd_word_nxt;
    end
    assign interrupt_disable = cmd_word_r[POS_INT_DISABLE];

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    irc_intx u_intx (
        .clk                     (clk),
        .rstn                    (rstn),
        .ce                      (ce),
        .int_state               (int_state),
        .interrupt_disable       (interrupt_disable),
        .interrupt_pending       (interrupt_pending),
        .legacy_interrupt_line_c (int_line)
    );
    assign legacy_interrupt_line_c = int_line;

    irc_base_reg #(.WMASK(CMD_BASE_WMASK)) u_cmdb (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .reload (reload),
        .wr     (wr_cmdb),
        .be     (cfg_be),
        .wdata  (cfg_wdata),
        .q      (cmd_base)
    );

    irc_base_reg #(.WMASK(CTL_BASE_WMASK)) u_ctlb (
        .clk    (clk),
        .rstn   (rstn),
        .ce     (ce),
        .reload (reload),
        .wr     (wr_ctlb),
        .be     (cfg_be),
        .wdata  (cfg_wdata),
        .q      (ctl_base)
    );

    // ------------------------------------------------------------
    // status word: fixed bits plus pending
    // ------------------------------------------------------------
    always_comb
    begin
        device_status_word = STS_FIXED;
        device_status_word[POS_INT_PENDING] = interrupt_pending;
    end

    // ------------------------------------------------------------
    // read mux, registered answer one cycle after request
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (hit(cfg_addr, OFS_CMD_STAT))
            rdata_nxt = {device_status_word, cmd_word_r};
        else if (hit(cfg_addr, OFS_REV_CLASS))
            rdata_nxt = {CLASS_TRIPLET, silicon_revision};
        else if (hit(cfg_addr, OFS_LINE_TMR))
            rdata_nxt = {16'h0000, HOLD_TMR_VAL, LINE_SIZE_VAL};
        else if (hit(cfg_addr, OFS_CMD_BASE))
            rdata_nxt = cmd_base;
        else if (hit(cfg_addr, OFS_CTL_BASE))
            rdata_nxt = ctl_base;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_rdata <= 32'h00000000;
            cfg_ack   <= 1'b0;
        end
        else if (ce)
        begin
            cfg_rdata <= cfg_rd ? rdata_nxt : 32'h00000000;
            cfg_ack   <= cfg_rd | cfg_wr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sts_fixed: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg_rd && hit(cfg_addr, OFS_CMD_STAT) |=>
        (cfg_rdata[31:16] & 16'hfff7) == 16'h00b0)
        else $error("status word fixed bits wrong");
    a_class_read: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg_rd && hit(cfg_addr, OFS_REV_CLASS) |=> cfg_rdata[31:8] == 24'h010185)
        else $error("class triplet wrong");
    a_line_timer: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg_rd && hit(cfg_addr, OFS_LINE_TMR) |=> cfg_rdata[15:0] == 16'h0000)
        else $error("line size or hold timer not zero");
    a_cmdb_mask: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr_cmdb && cfg_be == 4'hf && !reload |=>
        cmd_base == ((($past(cfg_wdata)) & 32'h0000fff8) | 32'h1))
        else $error("command base write wrong");
    a_ctlb_mask: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr_ctlb && cfg_be == 4'hf && !reload |=>
        ctl_base == ((($past(cfg_wdata)) & 32'h0000fffc) | 32'h1))
        else $error("control base write wrong");
    a_d3_reload: assert property (@(posedge clk) disable iff (!rstn)
        ce && reload |=> cmd_base == 32'h1 && ctl_base == 32'h1)
        else $error("bases not reloaded on d3 to d0");
    a_int_gate: assert property (@(posedge clk) disable iff (!rstn)
        ce ##1 ce && interrupt_disable && $stable(interrupt_disable) |=> !legacy_interrupt_line_c)
        else $error("interrupt line not gated");
endmodule : irc_cfg_header

// *** irc_host_model.sv ***
// host side model issuing configuration reads and writes
`timescale 1ns/10ps
module irc_host_model
    import irc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata
);
    // idle bus at time zero
    initial
    begin
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0;
    end

    // one access: pulse for one cycle, scramble released lines, wait for ack
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
        int i;
        ok    = 1'b0;
        rdata = 32'h0;
        @(negedge clk);
        cfg_rd    = ~wr;
        cfg_wr    = wr;
        cfg_addr  = addr;
        cfg_be    = be;
        cfg_wdata = wdata;
        @(negedge clk);
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = ~cfg_addr;
        cfg_be    = ~cfg_be;
        cfg_wdata = ~cfg_wdata;
        for (i = 0; i < 4 && !ok; i++)
        begin
            if (cfg_ack === 1'b1)
            begin
                ok    = 1'b1;
                rdata = cfg_rdata;
            end
            else
                @(negedge clk);
        end
    endtask : xfer
endmodule : irc_host_model

// *** ide_redirect_pci_config_header_tb_top.sv ***
// self-checking testbench of the configuration header block
`timescale 1ns/10ps
module ide_redirect_pci_config_header_tb_top
    import irc_pkg::*;
;
    logic        clk, rstn, ce, int_state, cfg_rd, cfg_wr, cfg_ack, line_c;
    logic [1:0]  pwr_state;
    logic [7:0]  rev, cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, cmd_base, ctl_base;
    int          num_errors, n_checks, cyc;

    irc_cfg_header irc_cfg_header_i (.clk(clk), .rstn(rstn), .ce(ce), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .pwr_state(pwr_state),
        .int_state(int_state), .silicon_revision(rev), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .legacy_interrupt_line_c(line_c), .cmd_base(cmd_base), .ctl_base(ctl_base));
    irc_host_model irc_host_model_i (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] r;
        logic        ok;
        irc_host_model_i.xfer(1'b1, a, be, d, r, ok);
        chk({31'h0, ok}, 32'h1);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        ok;
        irc_host_model_i.xfer(1'b0, a, 4'h0, 32'h0, r, ok);
        chk({31'h0, ok}, 32'h1);
        chk(r, exp);
    endtask : rc

    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rc(8'h04, 32'h00b00000);
        rc(8'h08, 32'h0101855a);
        rc(8'h0c, 32'h00000000);
        rc(8'h10, 32'h00000001);
        rc(8'h14, 32'h00000001);
        rc(8'h40, 32'h00000000);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_readonly();
        wr(8'h04, 4'hf, 32'hffffffff);
        rc(8'h04, 32'h00b00405);
        wr(8'h08, 4'hf, 32'hffffffff);
        wr(8'h0c, 4'hf, 32'hffffffff);
        rev = 8'ha5;
        rc(8'h08, 32'h010185a5);
        rc(8'h0c, 32'h00000000);
        wr(8'h04, 4'hf, 32'h00000000);
        $display("test readonly done");
    endtask : t_readonly

    task automatic t_bases();
        wr(8'h10, 4'h2, 32'h12345678);
        rc(8'h10, 32'h00005601);
        wr(8'h10, 4'hf, 32'hffffffff);
        wr(8'h14, 4'hf, 32'hffffffff);
        rc(8'h10, 32'h0000fff9);
        rc(8'h14, 32'h0000fffd);
        chk(cmd_base, 32'h0000fff9);
        chk(ctl_base, 32'h0000fffd);
        $display("test bases done");
    endtask : t_bases

    task automatic t_interrupt();
        int_state = 1'b1;
        waitn(3);
        chk({31'h0, line_c}, 32'h1);
        rc(8'h04, 32'h00b80000);
        wr(8'h04, 4'h3, 32'h00000400);
        waitn(1);
        chk({31'h0, line_c}, 32'h0);
        rc(8'h04, 32'h00b80400);
        int_state = 1'b0;
        wr(8'h04, 4'h3, 32'h00000000);
        waitn(2);
        chk({31'h0, line_c}, 32'h0);
        rc(8'h04, 32'h00b00000);
        $display("test interrupt done");
    endtask : t_interrupt

    task automatic t_power();
        wr(8'h04, 4'h3, 32'h00000405);
        pwr_state = 2'h3;
        waitn(6);
        pwr_state = 2'h0;
        waitn(8);
        chk(cmd_base, 32'h00000001);
        chk(ctl_base, 32'h00000001);
        rc(8'h04, 32'h00b00000);
        wr(8'h14, 4'hf, 32'h0000abcd);
        rstn = 1'b0;
        waitn(2);
        rstn = 1'b1;
        waitn(1);
        chk(ctl_base, 32'h00000001);
        rc(8'h14, 32'h00000001);
        $display("test power done");
    endtask : t_power

    // ------------------------------------------------------------
    // closing report
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // clock of 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        num_errors = 0;
        n_checks   = 0;
        cyc        = 0;
        rstn       = 1'b0;
        ce         = 1'b1;
        int_state  = 1'b0;
        pwr_state  = 2'h0;
        rev        = 8'h5a;
        waitn(10);
        rstn = 1'b1;
        t_defaults();
        t_readonly();
        t_bases();
        t_interrupt();
        t_power();
        stop_test();
    end
endmodule : ide_redirect_pci_config_header_tb_top
